// >>> design/ttx_pkg.sv
// Purpose: shared constants of the timer transfer instruction block
// Assumes: 10-bit instruction words, 4-bit data path
// Notes:   opcodes are the hexadecimal instruction codes

package ttx_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int OP_W     = 10;
    localparam int NIB_W    = 4;
    localparam int HI_W     = 2;
    localparam int T1_W     = 10;
    localparam int T2_W     = 8;
    localparam int T3_W     = 8;

    // ----------------------------------------------------------------
    // control register fields and reset values
    // ----------------------------------------------------------------
    localparam int RUN_BIT                 = 0;
    localparam logic [NIB_W-1:0] CTRL_RST  = 4'h0;
    localparam logic [HI_W-1:0]  HI_RST    = 2'h0;
    localparam logic [T1_W-1:0]  T1_RST    = 10'h000;
    localparam logic [T2_W-1:0]  T2_RST    = 8'h00;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [OP_W-1:0] OP_READ_T1      = 10'h270;
    localparam logic [OP_W-1:0] OP_WRITE_T1     = 10'h230;
    localparam logic [OP_W-1:0] OP_READ_T2      = 10'h271;
    localparam logic [OP_W-1:0] OP_WRITE_T2     = 10'h231;
    localparam logic [OP_W-1:0] OP_WRITE_T2_RLD = 10'h23a;
    localparam logic [OP_W-1:0] OP_READ_T3      = 10'h272;
    localparam logic [OP_W-1:0] OP_WRITE_T3     = 10'h232;
    localparam logic [OP_W-1:0] OP_WRITE_T3_HI  = 10'h23d;
    localparam logic [OP_W-1:0] OP_READ_HI      = 10'h24f;
    localparam logic [OP_W-1:0] OP_WRITE_HI     = 10'h212;
    localparam logic [OP_W-1:0] OP_READ_CTL1    = 10'h24b;
    localparam logic [OP_W-1:0] OP_WRITE_CTL1   = 10'h20e;
    localparam logic [OP_W-1:0] OP_READ_CTL2    = 10'h24c;
    localparam logic [OP_W-1:0] OP_WRITE_CTL2   = 10'h20f;
    localparam logic [OP_W-1:0] OP_READ_CTL3    = 10'h24d;
    localparam logic [OP_W-1:0] OP_WRITE_CTL3   = 10'h210;

endpackage

// >>> design/ttx_reload_timer.sv
// Purpose: down counter with a reload register
// Assumes: tick comes from logic on clk
// Notes:   underflow reloads the counter from the reload register

`timescale 1ns/1ps

module ttx_reload_timer #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         run,
    input  wire logic         tick,
    // writes from the decoder
    input  wire logic         load_both,
    input  wire logic         load_reload,
    input  wire logic [W-1:0] load_value,
    // state
    output logic      [W-1:0] count,
    output logic              underflow
);

    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] reload;
        logic         underflow;
    } ttx_tmr_t;

    ttx_tmr_t st;
    ttx_tmr_t next_st;

    always_comb begin
        next_st           = st;
        next_st.underflow = 1'b0;
        if (load_both) begin
            next_st.count  = load_value;
            next_st.reload = load_value;
        end else begin
            if (load_reload) begin
                // new reload value waits for the next underflow
                next_st.reload = load_value;
            end
            if (run && tick) begin
                if (st.count == '0) begin
                    next_st.count     = st.reload;
                    next_st.underflow = 1'b1;
                end else begin
                    next_st.count = st.count - W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count     = st.count;
    assign underflow = st.underflow;

endmodule

// >>> design/ttx_decoder.sv
// Purpose: executes the timer transfer instructions of the 4-bit core
// Assumes: core presents one instruction per cycle with its A and B values
// Notes:   results appear one cycle after the instruction is taken

`timescale 1ns/1ps

// Summary of operation
// - timer one read splits count into store, B, A
// - stopped timer one write loads counter and reload
// - running timer one write loads reload only
// - timer two read gives count in B, A
// - timer two write loads counter and reload
// - timer two reload write loads reload only
// - timer three read gives count in B, A
// - timer three write loads counter and low reload
// - high reload write loads high reload only
// - store read zero-extends two bits into A
// - store write takes A bits one, zero
// - control registers one to three read/write via A
module ttx_decoder
    import ttx_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // instruction from the core
    input  wire logic                 op_valid,
    input  wire logic [ttx_pkg::OP_W-1:0]  op_code,
    input  wire logic [ttx_pkg::NIB_W-1:0] acc_in,
    input  wire logic [ttx_pkg::NIB_W-1:0] b_in,
    // count prescaler strobe
    input  wire logic                 count_tick,
    // results back to the core
    output logic                      acc_we,
    output logic [ttx_pkg::NIB_W-1:0] acc_out,
    output logic                      b_we,
    output logic [ttx_pkg::NIB_W-1:0] b_out,
    output logic                      op_done,
    output logic                      skip_next,
    output logic                      carry_we,
    // timer underflow flags
    output logic                      timer1_flag,
    output logic                      timer2_flag,
    output logic                      timer3_flag
);
    import ttx_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              acc_we;
        logic [NIB_W-1:0]  acc_out;
        logic              b_we;
        logic [NIB_W-1:0]  b_out;
        logic              op_done;
        logic [HI_W-1:0]   timer1_high_bits_store;
        logic [NIB_W-1:0]  timer_control_one;
        logic [NIB_W-1:0]  timer_control_two;
        logic [NIB_W-1:0]  timer_control_three;
        logic [T3_W-1:0]   timer3_high_reload;
        logic              t1f;
        logic              t2f;
        logic              t3f;
    } ttx_state_t;

    ttx_state_t st;
    ttx_state_t next_st;

    logic [T1_W-1:0] t1_count;
    logic [T2_W-1:0] t2_count;
    logic [T3_W-1:0] t3_count;
    logic            t1_uf;
    logic            t2_uf;
    logic            t3_uf;
    logic            t1_both;
    logic            t1_rld;
    logic            t2_both;
    logic            t2_rld;
    logic            t3_both;
    logic            timer_one_run_bit;

    assign timer_one_run_bit = st.timer_control_one[RUN_BIT];

    // ----------------------------------------------------------------
    // write strobes towards the counters
    // ----------------------------------------------------------------
    always_comb begin
        t1_both = 1'b0;
        t1_rld  = 1'b0;
        t2_both = 1'b0;
        t2_rld  = 1'b0;
        t3_both = 1'b0;
        if (op_valid) begin
            case (op_code)
                OP_WRITE_T1: begin
                    t1_both = !timer_one_run_bit;
                    t1_rld  = timer_one_run_bit;
                end
                OP_WRITE_T2:     t2_both = 1'b1;
                OP_WRITE_T2_RLD: t2_rld  = 1'b1;
                OP_WRITE_T3:     t3_both = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // decode and register transfers
    // ----------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.acc_we  = 1'b0;
        next_st.b_we    = 1'b0;
        next_st.op_done = op_valid;
        // a new underflow wins over nothing; flags mirror the counters
        next_st.t1f     = t1_uf;
        next_st.t2f     = t2_uf;
        next_st.t3f     = t3_uf;
        if (op_valid) begin
            case (op_code)
                OP_READ_T1: begin
                    next_st.timer1_high_bits_store = t1_count[9:8];
                    next_st.b_out   = t1_count[7:4];
                    next_st.acc_out = t1_count[3:0];
                    next_st.b_we    = 1'b1;
                    next_st.acc_we  = 1'b1;
                end
                OP_READ_T2: begin
                    next_st.b_out   = t2_count[7:4];
                    next_st.acc_out = t2_count[3:0];
                    next_st.b_we    = 1'b1;
                    next_st.acc_we  = 1'b1;
                end
                OP_READ_T3: begin
                    next_st.b_out   = t3_count[7:4];
                    next_st.acc_out = t3_count[3:0];
                    next_st.b_we    = 1'b1;
                    next_st.acc_we  = 1'b1;
                end
                OP_WRITE_T3_HI: begin
                    next_st.timer3_high_reload = {b_in, acc_in};
                end
                OP_READ_HI: begin
                    next_st.acc_out = {2'h0, st.timer1_high_bits_store};
                    next_st.acc_we  = 1'b1;
                end
                OP_WRITE_HI: begin
                    next_st.timer1_high_bits_store = acc_in[1:0];
                end
                OP_READ_CTL1: begin
                    next_st.acc_out = st.timer_control_one;
                    next_st.acc_we  = 1'b1;
                end
                OP_WRITE_CTL1: next_st.timer_control_one   = acc_in;
                OP_READ_CTL2: begin
                    next_st.acc_out = st.timer_control_two;
                    next_st.acc_we  = 1'b1;
                end
                OP_WRITE_CTL2: next_st.timer_control_two   = acc_in;
                OP_READ_CTL3: begin
                    next_st.acc_out = st.timer_control_three;
                    next_st.acc_we  = 1'b1;
                end
                OP_WRITE_CTL3: next_st.timer_control_three = acc_in;
                OP_WRITE_T1, OP_WRITE_T2, OP_WRITE_T2_RLD, OP_WRITE_T3: begin
                    // counter loads come from the strobe decoder above
                end
                default: begin
                    // other instructions belong to other units
                    next_st.op_done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st                        <= '0;
            st.timer1_high_bits_store <= HI_RST;
            st.timer_control_one      <= CTRL_RST;
            st.timer_control_two      <= CTRL_RST;
            st.timer_control_three    <= CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    // timer three reloads from the low reload only; high value is held
    ttx_reload_timer #(.W(T1_W)) u_timer1 (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (timer_one_run_bit),
        .tick        (count_tick),
        .load_both   (t1_both),
        .load_reload (t1_rld),
        .load_value  ({st.timer1_high_bits_store, b_in, acc_in}),
        .count       (t1_count),
        .underflow   (t1_uf)
    );

    ttx_reload_timer #(.W(T2_W)) u_timer2 (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (st.timer_control_two[RUN_BIT]),
        .tick        (count_tick),
        .load_both   (t2_both),
        .load_reload (t2_rld),
        .load_value  ({b_in, acc_in}),
        .count       (t2_count),
        .underflow   (t2_uf)
    );

    ttx_reload_timer #(.W(T3_W)) u_timer3 (
        .clk         (clk),
        .rst_n       (rst_n),
        .run         (st.timer_control_three[RUN_BIT]),
        .tick        (count_tick),
        .load_both   (t3_both),
        .load_reload (1'b0),
        .load_value  ({b_in, acc_in}),
        .count       (t3_count),
        .underflow   (t3_uf)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign acc_we      = st.acc_we;
    assign acc_out     = st.acc_out;
    assign b_we        = st.b_we;
    assign b_out       = st.b_out;
    assign op_done     = st.op_done;
    assign skip_next   = 1'b0;
    assign carry_we    = 1'b0;
    assign timer1_flag = st.t1f;
    assign timer2_flag = st.t2f;
    assign timer3_flag = st.t3f;

endmodule

// >>> bench/ttx_monitor.sv
// Purpose: port checker for ttx_decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every ttx_decoder instance
`timescale 1ns/1ps
module ttx_monitor
    import ttx_pkg::*;
(
    // clock and reset
    input wire logic                      clk,
    input wire logic                      rst_n,
    // instruction
    input wire logic                      op_valid,
    input wire logic [ttx_pkg::OP_W-1:0]  op_code,
    input wire logic [ttx_pkg::NIB_W-1:0] acc_in,
    input wire logic [ttx_pkg::NIB_W-1:0] b_in,
    input wire logic                      count_tick,
    // results
    input wire logic                      acc_we,
    input wire logic [ttx_pkg::NIB_W-1:0] acc_out,
    input wire logic                      b_we,
    input wire logic [ttx_pkg::NIB_W-1:0] b_out,
    input wire logic                      op_done,
    input wire logic                      skip_next,
    input wire logic                      carry_we
);
    logic known;
    always_comb known = op_code inside {OP_READ_T1, OP_WRITE_T1, OP_READ_T2, OP_WRITE_T2, OP_WRITE_T2_RLD,
        OP_READ_T3, OP_WRITE_T3, OP_WRITE_T3_HI, OP_READ_HI, OP_WRITE_HI, OP_READ_CTL1, OP_WRITE_CTL1,
        OP_READ_CTL2, OP_WRITE_CTL2, OP_READ_CTL3, OP_WRITE_CTL3};
    // operands passed in so they are taken as sampled values
    function automatic logic on(logic v, logic [OP_W-1:0] code, logic [OP_W-1:0] c);
        return v && code == c;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_done; op_valid && known |=> op_done; endproperty
    a_done: assert property (p_done) else $error("instruction not done next cycle");
    property p_refuse; op_valid && !known |=> !op_done; endproperty
    a_refuse: assert property (p_refuse) else $error("unknown code executed");
    property p_quiet; skip_next == 1'b0 && carry_we == 1'b0; endproperty
    a_quiet: assert property (p_quiet) else $error("skip or carry touched");
    property p_rd_t2; on(op_valid, op_code, OP_READ_T2) |=> acc_we && b_we; endproperty
    a_rd_t2: assert property (p_rd_t2) else $error("timer two read wrote no A or B");
    property p_rd_hi; on(op_valid, op_code, OP_READ_HI) |=> acc_we && !b_we && acc_out[3:2] == 2'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("store read upper bits wrong");
    property p_wr_t2; on(op_valid, op_code, OP_WRITE_T2) |=> !acc_we && !b_we; endproperty
    a_wr_t2: assert property (p_wr_t2) else $error("timer two write touched A or B");
    property p_ctl;
        on(op_valid, op_code, OP_WRITE_CTL2) ##2 on(op_valid, op_code, OP_READ_CTL2)
        |=> acc_out == $past(acc_in, 3);
    endproperty
    a_ctl: assert property (p_ctl) else $error("control two read back wrong");
    property p_t3;
        on(op_valid, op_code, OP_WRITE_T3) ##2 (on(op_valid, op_code, OP_READ_T3) && !count_tick
        && !$past(count_tick))
        |=> {b_out, acc_out} == {$past(b_in, 3), $past(acc_in, 3)};
    endproperty
    a_t3: assert property (p_t3) else $error("timer three read back wrong");
    property p_hi;
        on(op_valid, op_code, OP_WRITE_HI) ##2 on(op_valid, op_code, OP_READ_HI)
        |=> {2'h0, acc_out[1:0]} == ($past(acc_in, 3) & 4'h3);
    endproperty
    a_hi: assert property (p_hi) else $error("store read back wrong");
endmodule
bind ttx_decoder ttx_monitor ttx_monitor_i (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .acc_in(acc_in), .b_in(b_in), .count_tick(count_tick), .acc_we(acc_we), .acc_out(acc_out), .b_we(b_we),
    .b_out(b_out), .op_done(op_done), .skip_next(skip_next), .carry_we(carry_we));

// >>> bench/ttx_core_model.sv
// Purpose: processor core side issuing timer transfer instructions
// Assumes: one instruction per call, results written back by the strobes
// Notes:   idle operands are inverted so stale values never look live
`timescale 1ns/1ps
module ttx_core_model
    import ttx_pkg::*;
(
    // clock
    input  wire logic                      clk,
    // instruction
    output logic                           op_valid,
    output logic [ttx_pkg::OP_W-1:0]       op_code,
    output logic [ttx_pkg::NIB_W-1:0]      acc_in,
    output logic [ttx_pkg::NIB_W-1:0]      b_in,
    // results
    input  wire logic                      acc_we,
    input  wire logic [ttx_pkg::NIB_W-1:0] acc_out,
    input  wire logic                      b_we,
    input  wire logic [ttx_pkg::NIB_W-1:0] b_out
);
    logic [NIB_W-1:0] acc = 4'h0;
    logic [NIB_W-1:0] b   = 4'h0;
    initial begin
        op_valid = 1'b0;
        op_code  = 10'h000;
        acc_in   = 4'h0;
        b_in     = 4'h0;
    end
    always @(posedge clk) begin
        if (acc_we) begin
            acc <= acc_out;
        end
        if (b_we) begin
            b <= b_out;
        end
    end
    task automatic exec(input logic [OP_W-1:0] op, input logic [NIB_W-1:0] a, input logic [NIB_W-1:0] bv);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= op;
        acc_in   <= a;
        b_in     <= bv;
        @(posedge clk);
        op_valid <= 1'b0;
        acc_in   <= ~a;
        b_in     <= ~bv;
    endtask
endmodule

// >>> bench/test_timer_transfer_instructions.sv
// Purpose: self-checking bench for ttx_decoder
// Assumes: core model issues instructions, bench drives count_tick
// Notes:   timers stopped between scenarios so reads are stable
`timescale 1ns/1ps
module test_timer_transfer_instructions;
    import ttx_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              count_tick = 1'b0;
    logic              op_valid, acc_we, b_we, op_done;
    logic [OP_W-1:0]   op_code;
    logic [NIB_W-1:0]  acc_in, b_in, acc_out, b_out;
    logic [2:0]        flag, seen = 3'h0;
    int                fails = 0;
    int                n_compared = 0;
    logic [OP_W-1:0]   wctl [3] = '{OP_WRITE_CTL1, OP_WRITE_CTL2, OP_WRITE_CTL3};
    logic [OP_W-1:0]   rctl [3] = '{OP_READ_CTL1, OP_READ_CTL2, OP_READ_CTL3};
    always #2 clk = ~clk;
    ttx_decoder ttx_decoder_i (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .acc_in(acc_in), .b_in(b_in), .count_tick(count_tick), .acc_we(acc_we), .acc_out(acc_out),
        .b_we(b_we), .b_out(b_out), .op_done(op_done), .skip_next(), .carry_we(),
        .timer1_flag(flag[0]), .timer2_flag(flag[1]), .timer3_flag(flag[2]));
    ttx_core_model ttx_core_model_i (.clk(clk), .op_valid(op_valid), .op_code(op_code), .acc_in(acc_in),
        .b_in(b_in), .acc_we(acc_we), .acc_out(acc_out), .b_we(b_we), .b_out(b_out));
    always @(posedge clk) seen <= seen | flag;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [OP_W-1:0] op, input logic [7:0] v);
        ttx_core_model_i.exec(op, v[3:0], v[7:4]);
    endtask
    // full selects B:A, otherwise only A is compared
    task automatic rd(input logic [OP_W-1:0] op, input logic [7:0] exp, input logic full);
        ttx_core_model_i.exec(op, 4'h0, 4'h0);
        @(posedge clk);
        #1;
        check({full ? ttx_core_model_i.b : 4'h0, ttx_core_model_i.acc}, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            count_tick <= 1'b1;
            @(posedge clk);
            count_tick <= 1'b0;
        end
    endtask
    // the loaded count of 2 stays put under a reload-only write, then three ticks reach the new reload
    task automatic reload_case(input logic [OP_W-1:0] ctl, both, rld, rdop, input logic [2:0] f);
        wr(ctl, 8'h00);
        wr(both, 8'h02);
        wr(ctl, 8'h01);
        wr(rld, 8'ha5);
        rd(rdop, 8'h02, 1'b1);
        tick(3);
        wr(ctl, 8'h00);
        rd(rdop, 8'ha5, 1'b1);
        check({5'h0, seen & f}, {5'h0, f});
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(wctl[i], 8'h0a + 8'(2 * i));
            rd(rctl[i], 8'h0a + 8'(2 * i), 1'b0);
        end
        $display("control registers done");
        wr(OP_WRITE_HI, 8'h06);
        wr(OP_WRITE_T1, 8'h59);
        wr(OP_WRITE_HI, 8'h00);
        rd(OP_READ_T1, 8'h59, 1'b1);
        rd(OP_READ_HI, 8'h02, 1'b0);
        wr(OP_WRITE_HI, 8'h07);
        rd(OP_READ_HI, 8'h03, 1'b0);
        wr(OP_WRITE_HI, 8'h00);
        reload_case(OP_WRITE_CTL1, OP_WRITE_T1, OP_WRITE_T1, OP_READ_T1, 3'h1);
        $display("timer one done");
        wr(OP_WRITE_T2, 8'hc3);
        rd(OP_READ_T2, 8'hc3, 1'b1);
        reload_case(OP_WRITE_CTL2, OP_WRITE_T2, OP_WRITE_T2_RLD, OP_READ_T2, 3'h2);
        $display("timer two done");
        wr(OP_WRITE_T3, 8'h94);
        rd(OP_READ_T3, 8'h94, 1'b1);
        wr(OP_WRITE_T3_HI, 8'h3e);
        rd(OP_READ_T3, 8'h94, 1'b1);
        // low reload of 2 comes back after underflow, high reload plays no part
        wr(OP_WRITE_CTL3, 8'h00);
        wr(OP_WRITE_T3, 8'h02);
        wr(OP_WRITE_CTL3, 8'h01);
        tick(3);
        wr(OP_WRITE_CTL3, 8'h00);
        rd(OP_READ_T3, 8'h02, 1'b1);
        check({5'h0, seen & 3'h4}, 8'h04);
        wr(10'h3ff, 8'h00);
        $display("timer three done");
        close_out();
    end
endmodule
